// file: core/flt_entry.sv
// one lookup entry: threshold compare and duty formatting
`timescale 1ns/1ps
module flt_entry (
  // stored register values
  input wire logic [7:0] thr_reg,
  input wire logic [7:0] duty_reg,
  // mode and context
  input wire logic temp_high_res,
  input wire logic duty_high_res,
  input wire logic pwm_freq_22k5,
  input wire logic [7:0] temp_offset,
  input wire logic [9:0] temp_half_deg,
  input wire logic temp_neg,
  // results
  output wire logic exceeded,
  output wire logic [7:0] duty,
  output wire logic [7:0] thr_view,
  output wire logic [7:0] duty_view
);
  import flt_pkg::*;

  wire logic half_bit;
  wire logic [6:0] thr_deg;
  wire logic [8:0] deg_sum;
  wire logic [9:0] thr_half;
  wire logic ext_on;
  wire logic [1:0] duty_ext;

  // half degree bit only counts in high resolution
  assign half_bit = temp_high_res & thr_reg[FLT_THR_HALF_BIT];
  assign thr_deg = thr_reg[FLT_THR_DEG_MSB:0];
  // threshold unsigned, offset raises it above 127
  assign deg_sum = {2'b00, thr_deg} + {1'b0, temp_offset};
  assign thr_half = {deg_sum, half_bit};
  assign exceeded = !temp_neg && (temp_half_deg > thr_half);
  // extension only in high resolution at 22.5 kHz
  assign ext_on = duty_high_res & pwm_freq_22k5;
  assign duty_ext = ext_on ? duty_reg[7:FLT_DUTY_EXT_LSB] : FLT_DUTY_EXT_OFF;
  assign duty = {duty_ext, duty_reg[FLT_DUTY_BASE_MSB:0]};
  assign thr_view = {half_bit, thr_deg};
  assign duty_view = duty_high_res ? duty_reg :
                     {FLT_DUTY_EXT_OFF, duty_reg[FLT_DUTY_BASE_MSB:0]};
endmodule

// file: core/flt_lut_entries.sv
// fan lookup table entries five and six: registers and duty selection
`timescale 1ns/1ps
// What this block does
// - low resolution temperature mode forces threshold top bit to zero.
// - high resolution uses top bit as half degree, range 0 to 127.5.
// - low resolution threshold range is 0 to 127 in whole degrees.
// - temperature above entry five threshold selects duty register 0x59.
// - temperature above entry six threshold selects duty register 0x5B.
// - compare uses nine temperature bits high resolution, eight in low.
// - thresholds are positive only, sign bit taken as zero.
// - lookup temperature offset adds to thresholds for higher limits.
// - low resolution duty mode forces duty top two bits to zero.
// - high resolution duty joins top two bits and lower six bits.
// - duty top bits act only with 22.5 kHz pwm frequency.
// - low resolution duty value comes from the lower six bits.
module flt_lut_entries (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output wire logic reg_hit,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // configuration from the rest of the unit
  input wire logic lut_write_enable,
  input wire logic temp_lut_high_res,
  input wire logic duty_lut_high_res,
  input wire logic pwm_freq_22k5,
  input wire logic [7:0] lut_temp_offset,
  // remote temperature, eighth degree units
  input wire logic remote_temp_neg,
  input wire logic [10:0] remote_temp,
  // duty result to the pwm engine
  output logic lut_duty_valid,
  output logic [7:0] lut_duty,
  output flt_pkg::flt_entry_t lut_active_entry
);
  import flt_pkg::*;

  logic [7:0] e5_thr_reg;
  logic [7:0] e5_duty_reg;
  logic [7:0] e6_thr_reg;
  logic [7:0] e6_duty_reg;

  wire logic hit_e5_thr;
  wire logic hit_e5_duty;
  wire logic hit_e6_thr;
  wire logic hit_e6_duty;
  wire logic wr_ok;
  wire logic [9:0] temp_half_deg;
  wire logic e5_exceeded;
  wire logic e6_exceeded;
  wire logic [7:0] e5_duty;
  wire logic [7:0] e6_duty;
  wire logic [7:0] e5_thr_view;
  wire logic [7:0] e5_duty_view;
  wire logic [7:0] e6_thr_view;
  wire logic [7:0] e6_duty_view;
  wire logic [7:0] rdata_next;
  wire logic duty_valid_next;
  wire logic [7:0] duty_next;
  flt_entry_t entry_next;

  // address decode
  assign hit_e5_thr = (reg_addr == FLT_ADDR_E5_THR);
  assign hit_e5_duty = (reg_addr == FLT_ADDR_E5_DUTY);
  assign hit_e6_thr = (reg_addr == FLT_ADDR_E6_THR);
  assign hit_e6_duty = (reg_addr == FLT_ADDR_E6_DUTY);
  assign reg_hit = hit_e5_thr | hit_e5_duty | hit_e6_thr | hit_e6_duty;
  assign wr_ok = reg_wr & lut_write_enable;

  // temperature in half degrees, nine or eight bits used
  assign temp_half_deg = temp_lut_high_res ?
    {1'b0, remote_temp[FLT_TEMP_MSB:FLT_TEMP_HALF_LSB]} :
    {1'b0, remote_temp[FLT_TEMP_MSB:FLT_TEMP_DEG_LSB], 1'b0};

  flt_entry u_entry5 (
    .thr_reg(e5_thr_reg),
    .duty_reg(e5_duty_reg),
    .temp_high_res(temp_lut_high_res),
    .duty_high_res(duty_lut_high_res),
    .pwm_freq_22k5(pwm_freq_22k5),
    .temp_offset(lut_temp_offset),
    .temp_half_deg(temp_half_deg),
    .temp_neg(remote_temp_neg),
    .exceeded(e5_exceeded),
    .duty(e5_duty),
    .thr_view(e5_thr_view),
    .duty_view(e5_duty_view)
  );

  flt_entry u_entry6 (
    .thr_reg(e6_thr_reg),
    .duty_reg(e6_duty_reg),
    .temp_high_res(temp_lut_high_res),
    .duty_high_res(duty_lut_high_res),
    .pwm_freq_22k5(pwm_freq_22k5),
    .temp_offset(lut_temp_offset),
    .temp_half_deg(temp_half_deg),
    .temp_neg(remote_temp_neg),
    .exceeded(e6_exceeded),
    .duty(e6_duty),
    .thr_view(e6_thr_view),
    .duty_view(e6_duty_view)
  );

  // read mux, masked views per mode
  assign rdata_next = hit_e5_thr ? e5_thr_view :
                      hit_e5_duty ? e5_duty_view :
                      hit_e6_thr ? e6_thr_view :
                      hit_e6_duty ? e6_duty_view : FLT_READ_ZERO;

  // entry six outranks entry five
  assign duty_valid_next = e5_exceeded | e6_exceeded;
  assign duty_next = e6_exceeded ? e6_duty :
                     e5_exceeded ? e5_duty : FLT_DUTY_IDLE;
  always_comb begin
    if (e6_exceeded) begin
      entry_next = FLT_ENTRY_6;
    end else if (e5_exceeded) begin
      entry_next = FLT_ENTRY_5;
    end else begin
      entry_next = FLT_ENTRY_NONE;
    end
  end

  // register storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      e5_thr_reg <= FLT_THR_RESET;
      e5_duty_reg <= FLT_DUTY_RESET;
      e6_thr_reg <= FLT_THR_RESET;
      e6_duty_reg <= FLT_DUTY_RESET;
    end else if (wr_ok) begin
      if (hit_e5_thr) e5_thr_reg <= reg_wdata;
      if (hit_e5_duty) e5_duty_reg <= reg_wdata;
      if (hit_e6_thr) e6_thr_reg <= reg_wdata;
      if (hit_e6_duty) e6_duty_reg <= reg_wdata;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= FLT_READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // duty output
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lut_duty_valid <= 1'b0;
      lut_duty <= FLT_DUTY_IDLE;
      lut_active_entry <= FLT_ENTRY_NONE;
    end else begin
      lut_duty_valid <= duty_valid_next;
      lut_duty <= duty_next;
      lut_active_entry <= entry_next;
    end
  end

  // checks
  property p_thr_low_msb;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && !temp_lut_high_res && (hit_e5_thr || hit_e6_thr)
      |=> reg_rvalid && !reg_rdata[FLT_THR_HALF_BIT];
  endproperty
  a_thr_low_msb: assert property (p_thr_low_msb)
    else $error("threshold top bit not zero in low resolution");

  property p_duty_low_ext;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && !duty_lut_high_res && (hit_e5_duty || hit_e6_duty)
      |=> reg_rdata[7:FLT_DUTY_EXT_LSB] == FLT_DUTY_EXT_OFF;
  endproperty
  a_duty_low_ext: assert property (p_duty_low_ext)
    else $error("duty top bits not zero in low resolution");

  property p_wr_blocked;
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && !lut_write_enable
      |=> $stable(e5_thr_reg) && $stable(e5_duty_reg)
          && $stable(e6_thr_reg) && $stable(e6_duty_reg);
  endproperty
  a_wr_blocked: assert property (p_wr_blocked)
    else $error("register changed with write enable clear");

  property p_wr_taken;
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && lut_write_enable && hit_e6_duty
      |=> e6_duty_reg == $past(reg_wdata);
  endproperty
  a_wr_taken: assert property (p_wr_taken)
    else $error("enabled write did not land");

  property p_e6_priority;
    @(posedge clk_sys) disable iff (!nrst)
    e6_exceeded
      |=> lut_active_entry == FLT_ENTRY_6 && lut_duty == $past(e6_duty);
  endproperty
  a_e6_priority: assert property (p_e6_priority)
    else $error("entry six duty not selected");

  property p_e5_select;
    @(posedge clk_sys) disable iff (!nrst)
    e5_exceeded && !e6_exceeded
      |=> lut_duty_valid && lut_duty == $past(e5_duty);
  endproperty
  a_e5_select: assert property (p_e5_select)
    else $error("entry five duty not selected");

  property p_ext_off;
    @(posedge clk_sys) disable iff (!nrst)
    !pwm_freq_22k5 ##1 lut_duty_valid
      |-> lut_duty[7:FLT_DUTY_EXT_LSB] == FLT_DUTY_EXT_OFF;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("duty extension active away from 22.5 kHz");

  property p_neg_none;
    @(posedge clk_sys) disable iff (!nrst)
    remote_temp_neg |=> !lut_duty_valid && lut_active_entry == FLT_ENTRY_NONE;
  endproperty
  a_neg_none: assert property (p_neg_none)
    else $error("negative temperature exceeded a threshold");

  property p_low_res_cmp;
    @(posedge clk_sys) disable iff (!nrst)
    !temp_lut_high_res && !remote_temp_neg && lut_temp_offset == FLT_READ_ZERO
      && remote_temp[FLT_TEMP_MSB:FLT_TEMP_DEG_LSB] > {1'b0, e5_thr_reg[6:0]}
      |=> lut_duty_valid;
  endproperty
  a_low_res_cmp: assert property (p_low_res_cmp)
    else $error("low resolution compare missed");

  property p_high_res_cmp;
    @(posedge clk_sys) disable iff (!nrst)
    temp_lut_high_res && !remote_temp_neg && lut_temp_offset == FLT_READ_ZERO
      && remote_temp[FLT_TEMP_MSB:FLT_TEMP_HALF_LSB]
         <= {1'b0, e5_thr_reg[6:0], e5_thr_reg[FLT_THR_HALF_BIT]}
      && remote_temp[FLT_TEMP_MSB:FLT_TEMP_HALF_LSB]
         <= {1'b0, e6_thr_reg[6:0], e6_thr_reg[FLT_THR_HALF_BIT]}
      |=> !lut_duty_valid;
  endproperty
  a_high_res_cmp: assert property (p_high_res_cmp)
    else $error("high resolution compare fired too early");

  property p_offset_raises;
    @(posedge clk_sys) disable iff (!nrst)
    !remote_temp_neg && !temp_lut_high_res
      && {1'b0, remote_temp[FLT_TEMP_MSB:FLT_TEMP_DEG_LSB]}
         <= {2'b00, e5_thr_reg[6:0]} + {1'b0, lut_temp_offset}
      && {1'b0, remote_temp[FLT_TEMP_MSB:FLT_TEMP_DEG_LSB]}
         <= {2'b00, e6_thr_reg[6:0]} + {1'b0, lut_temp_offset}
      |=> !lut_duty_valid;
  endproperty
  a_offset_raises: assert property (p_offset_raises)
    else $error("offset not applied to threshold");

  property p_hi_duty;
    @(posedge clk_sys) disable iff (!nrst)
    duty_lut_high_res && pwm_freq_22k5 && e6_exceeded
      |=> lut_duty == $past(e6_duty_reg);
  endproperty
  a_hi_duty: assert property (p_hi_duty)
    else $error("full eight bit duty not used");

  property p_low_duty;
    @(posedge clk_sys) disable iff (!nrst)
    !duty_lut_high_res && e6_exceeded
      |=> lut_duty == {FLT_DUTY_EXT_OFF, $past(e6_duty_reg[FLT_DUTY_BASE_MSB:0])};
  endproperty
  a_low_duty: assert property (p_low_duty)
    else $error("low resolution duty not from lower six bits");

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && !reg_hit |=> reg_rvalid && reg_rdata == FLT_READ_ZERO;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_rvalid_pulse;
    @(posedge clk_sys) disable iff (!nrst)
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("read valid without a read strobe");

  property p_thr_high_view;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && temp_lut_high_res && hit_e6_thr
      |=> reg_rdata == $past(e6_thr_reg);
  endproperty
  a_thr_high_view: assert property (p_thr_high_view)
    else $error("half degree bit lost on high resolution read");
endmodule

// file: core/flt_pkg.sv
// constants shared by the fan lookup entries five and six
package flt_pkg;
  localparam logic [7:0] FLT_ADDR_E5_THR = 8'h58;
  localparam logic [7:0] FLT_ADDR_E5_DUTY = 8'h59;
  localparam logic [7:0] FLT_ADDR_E6_THR = 8'h5A;
  localparam logic [7:0] FLT_ADDR_E6_DUTY = 8'h5B;
  localparam logic [7:0] FLT_THR_RESET = 8'h7F;
  localparam logic [7:0] FLT_DUTY_RESET = 8'h3F;
  localparam logic [7:0] FLT_READ_ZERO = 8'h00;
  localparam logic [7:0] FLT_DUTY_IDLE = 8'h00;
  localparam int FLT_THR_HALF_BIT = 7;
  localparam int FLT_THR_DEG_MSB = 6;
  localparam int FLT_DUTY_EXT_LSB = 6;
  localparam int FLT_DUTY_BASE_MSB = 5;
  localparam int FLT_TEMP_MSB = 10;
  localparam int FLT_TEMP_HALF_LSB = 2;
  localparam int FLT_TEMP_DEG_LSB = 3;
  localparam logic [1:0] FLT_DUTY_EXT_OFF = 2'h0;
  typedef enum logic [1:0] {
    FLT_ENTRY_NONE = 2'b00,
    FLT_ENTRY_5 = 2'b01,
    FLT_ENTRY_6 = 2'b10
  } flt_entry_t;
endpackage

// file: tb/flt_lut_entries_test.sv
// self-checking bench for fan lookup entries five and six
`timescale 1ns/1ps
module flt_lut_entries_test;
  import flt_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic reg_hit;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic lut_write_enable = 1'b0;
  logic temp_lut_high_res = 1'b1;
  logic duty_lut_high_res = 1'b1;
  logic pwm_freq_22k5 = 1'b1;
  logic [7:0] lut_temp_offset = 8'h00;
  logic remote_temp_neg = 1'b0;
  logic [10:0] remote_temp = 11'h000;
  logic lut_duty_valid;
  logic [7:0] lut_duty;
  flt_entry_t lut_active_entry;
  logic [7:0] mreg [4];
  int err_count = 0;
  int cmp_count = 0;

  always #25 clk_sys = ~clk_sys;

  flt_lut_entries u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_hit(reg_hit), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .lut_write_enable(lut_write_enable),
    .temp_lut_high_res(temp_lut_high_res), .duty_lut_high_res(duty_lut_high_res),
    .pwm_freq_22k5(pwm_freq_22k5), .lut_temp_offset(lut_temp_offset),
    .remote_temp_neg(remote_temp_neg), .remote_temp(remote_temp),
    .lut_duty_valid(lut_duty_valid), .lut_duty(lut_duty),
    .lut_active_entry(lut_active_entry)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic bit mapped(input logic [7:0] a);
    return a >= FLT_ADDR_E5_THR && a <= FLT_ADDR_E6_DUTY;
  endfunction

  // model view of a register read
  function automatic logic [7:0] rview(input logic [7:0] a);
    logic [7:0] v;
    if (!mapped(a)) return FLT_READ_ZERO;
    v = mreg[a[1:0]];
    if (!a[0] && !temp_lut_high_res) v[7] = 1'b0;
    if (a[0] && !duty_lut_high_res) v[7:6] = 2'b00;
    return v;
  endfunction

  function automatic int thr_half(input int i);
    return (int'(mreg[i][6:0]) + int'(lut_temp_offset)) * 2
      + (temp_lut_high_res ? int'(mreg[i][7]) : 0);
  endfunction

  function automatic int temp_half();
    return temp_lut_high_res ? int'(remote_temp[10:2]) : int'(remote_temp[10:3]) * 2;
  endfunction

  function automatic logic [7:0] eduty(input int i);
    logic [1:0] ext;
    ext = (duty_lut_high_res && pwm_freq_22k5) ? mreg[i][7:6] : 2'b00;
    return {ext, mreg[i][5:0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (lut_write_enable && mapped(a)) mreg[a[1:0]] = d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk({7'h00, reg_hit}, {7'h00, mapped(a)});
    chk(reg_rdata, rview(a));
  endtask

  task automatic duty_chk;
    bit x5;
    bit x6;
    @(posedge clk_sys);
    #1;
    x5 = !remote_temp_neg && temp_half() > thr_half(0);
    x6 = !remote_temp_neg && temp_half() > thr_half(2);
    chk(lut_duty, x6 ? eduty(3) : (x5 ? eduty(1) : FLT_DUTY_IDLE));
    chk({7'h00, lut_duty_valid}, {7'h00, x5 | x6});
    chk({6'h00, lut_active_entry}, {6'h00, x6, x5 & !x6});
  endtask

  task automatic model_reset;
    mreg[0] = FLT_THR_RESET;
    mreg[1] = FLT_DUTY_RESET;
    mreg[2] = FLT_THR_RESET;
    mreg[3] = FLT_DUTY_RESET;
  endtask

  initial begin
    #3000000;
    err_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h6407));
    model_reset();
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 'h57; a <= 'h5C; a++) rd(8'(a));
    duty_chk();
    $display("reset values test done");
    // threshold at 40.5 degrees, entry six out of reach
    wr(FLT_ADDR_E5_THR, 8'hA8);
    rd(FLT_ADDR_E5_THR);
    @(posedge clk_sys);
    lut_write_enable <= 1'b1;
    wr(FLT_ADDR_E5_THR, 8'hA8);
    wr(FLT_ADDR_E5_DUTY, 8'hC5);
    for (int m = 0; m < 4; m++) begin
      for (int t = 324; t <= 328; t += 4) begin
        @(posedge clk_sys);
        temp_lut_high_res <= m[0];
        pwm_freq_22k5 <= m[1];
        remote_temp <= 11'(t);
        duty_chk();
        rd(FLT_ADDR_E5_THR);
      end
    end
    $display("threshold boundary test done");
    for (int n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      temp_lut_high_res <= 1'($urandom);
      duty_lut_high_res <= 1'($urandom);
      pwm_freq_22k5 <= 1'($urandom);
      lut_write_enable <= ($urandom % 4) != 0;
      lut_temp_offset <= 8'($urandom % 129);
      remote_temp_neg <= ($urandom % 8) == 0;
      remote_temp <= 11'($urandom);
      wr(8'('h56 + $urandom % 8), 8'($urandom));
      rd(8'('h56 + $urandom % 8));
      duty_chk();
    end
    $display("random lookup test done");
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    model_reset();
    for (int a = 'h58; a <= 'h5B; a++) rd(8'(a));
    duty_chk();
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
